// >>> core/user_flash_serial_access.sv
// User flash array with serial address and data registers and a bus status port.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module user_flash_serial_access #(
  parameter int PROG_CYCLES  = ufm_serial_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = ufm_serial_pkg::ERASE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        addr_shift_clk,
  input  wire logic        addr_serial_in,
  input  wire logic        addr_shift_not_incr,
  input  wire logic        data_shift_clk,
  input  wire logic        data_shift_not_capture,
  input  wire logic        data_serial_in,
  output logic             data_serial_out,
  input  wire logic        program_req,
  input  wire logic        erase_req,
  input  wire logic        internal_osc_enable,
  input  wire logic        live_reprogram_req,
  output logic             live_reprogram_active,
  output logic             busy
);

  localparam int AW = ufm_serial_pkg::ADDR_W;
  localparam int DW = ufm_serial_pkg::DATA_W;
  localparam int CW = ufm_serial_pkg::CNT_W;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  ufm_serial_pkg::link_in_s raw_in;
  ufm_serial_pkg::link_in_s lvl;
  ufm_serial_pkg::link_in_s rise;

  always_comb begin
    raw_in.live_req    = live_reprogram_req;
    raw_in.osc_en      = internal_osc_enable;
    raw_in.erase_req   = erase_req;
    raw_in.program_req = program_req;
    raw_in.dshift      = data_shift_not_capture;
    raw_in.din         = data_serial_in;
    raw_in.dclk        = data_shift_clk;
    raw_in.ashift      = addr_shift_not_incr;
    raw_in.ain         = addr_serial_in;
    raw_in.aclk        = addr_shift_clk;
  end

  input_filter #(
    .W (ufm_serial_pkg::LINK_W)
  ) u_filter (
    .mclk  (mclk),
    .rst   (rst),
    .raw   (raw_in),
    .level (lvl),
    .rise  (rise)
  );

  // ---------------------------------------------------------------------------
  // Storage and serial registers
  // ---------------------------------------------------------------------------
  logic [DW-1:0]             mem_ff [ufm_serial_pkg::WORDS];
  logic [1:0]                wcnt_ff [ufm_serial_pkg::WORDS];
  logic [AW-1:0]             areg_ff;
  logic [DW-1:0]             dreg_ff;
  logic [AW-1:0]             op_addr_ff;
  logic [DW-1:0]             op_data_ff;
  logic [CW-1:0]             cnt_ff;
  logic                      lock_ff;
  logic                      ignored_ff;
  logic                      overprog_ff;
  ufm_serial_pkg::op_state_e state_ff;
  logic [DW-1:0]             rd_word;
  logic                      live;
  logic                      start_prog;
  logic                      start_erase;
  logic                      req_seen;
  logic                      op_done;
  logic                      prog_allowed;

  function automatic logic [CW-1:0] last_count(input int cycles);
    last_count = CW'(cycles - 1);
  endfunction : last_count

  assign live    = lvl.live_req;
  assign rd_word = mem_ff[areg_ff];

  // Address register: shift or increment, frozen without clock edges.
  always_ff @(posedge mclk) begin
    if (rst) begin
      areg_ff <= '0;
    end else if (rise.aclk && !live) begin
      if (lvl.ashift) begin
        areg_ff <= {areg_ff[AW-2:0], lvl.ain};
      end else begin
        areg_ff <= areg_ff + AW'(1);
      end
    end
  end

  // Data register: capture the addressed word or shift MSB first; both
  // registers may move in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dreg_ff <= '0;
    end else if (rise.dclk && !live) begin
      if (lvl.dshift) begin
        dreg_ff <= {dreg_ff[DW-2:0], lvl.din};
      end else begin
        dreg_ff <= rd_word;
      end
    end
  end

  assign data_serial_out = dreg_ff[DW-1];

  // ---------------------------------------------------------------------------
  // Program and erase sequencer
  // ---------------------------------------------------------------------------
  // Simultaneous program and erase are refused as a whole.
  assign req_seen     = rise.program_req | rise.erase_req;
  assign prog_allowed = !lock_ff && !live && !(lvl.program_req && lvl.erase_req);
  assign start_prog   = rise.program_req && !lvl.erase_req && state_ff == ufm_serial_pkg::ST_IDLE
                        && prog_allowed;
  assign start_erase  = rise.erase_req && !lvl.program_req && state_ff == ufm_serial_pkg::ST_IDLE
                        && prog_allowed;
  assign op_done      = lvl.osc_en &&
                        ((state_ff == ufm_serial_pkg::ST_PROG && cnt_ff == last_count(PROG_CYCLES))
                        || (state_ff == ufm_serial_pkg::ST_ERASE
                            && cnt_ff == last_count(ERASE_CYCLES)));

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff   <= ufm_serial_pkg::ST_IDLE;
      cnt_ff     <= '0;
      op_addr_ff <= '0;
      op_data_ff <= '0;
    end else begin
      case (state_ff)
        ufm_serial_pkg::ST_IDLE: begin
          cnt_ff <= '0;
          if (start_prog) begin
            state_ff   <= ufm_serial_pkg::ST_PROG;
            op_addr_ff <= areg_ff;
            op_data_ff <= dreg_ff;
          end else if (start_erase) begin
            state_ff   <= ufm_serial_pkg::ST_ERASE;
            op_addr_ff <= areg_ff;
          end
        end
        ufm_serial_pkg::ST_PROG, ufm_serial_pkg::ST_ERASE: begin
          // The sequence only advances while the oscillator runs.
          if (op_done) begin
            state_ff <= ufm_serial_pkg::ST_IDLE;
            cnt_ff   <= '0;
          end else if (lvl.osc_en) begin
            cnt_ff <= cnt_ff + CW'(1);
          end
        end
        default: begin
          state_ff <= ufm_serial_pkg::ST_IDLE;
          cnt_ff   <= '0;
        end
      endcase
    end
  end

  assign busy = state_ff != ufm_serial_pkg::ST_IDLE;

  // Flash array: program clears bits only; erase fills a sector with ones.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < ufm_serial_pkg::WORDS; i++) begin
        mem_ff[i]  <= ufm_serial_pkg::ERASED_WORD;
        wcnt_ff[i] <= '0;
      end
    end else if (op_done && state_ff == ufm_serial_pkg::ST_PROG) begin
      if (wcnt_ff[op_addr_ff] < 2'(ufm_serial_pkg::MAX_PROGRAMS)) begin
        mem_ff[op_addr_ff]  <= mem_ff[op_addr_ff] & op_data_ff;
        wcnt_ff[op_addr_ff] <= wcnt_ff[op_addr_ff] + 2'd1;
      end
    end else if (op_done && state_ff == ufm_serial_pkg::ST_ERASE) begin
      for (int i = 0; i < ufm_serial_pkg::SECTOR_WORDS; i++) begin
        mem_ff[{op_addr_ff[AW-1], 8'(i)}]  <= ufm_serial_pkg::ERASED_WORD;
        wcnt_ff[{op_addr_ff[AW-1], 8'(i)}] <= '0;
      end
    end
  end

  assign live_reprogram_active = live;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic        bus_req;
  logic        bus_wr;
  logic        wr_ctrl;
  logic        wr_status;
  logic        refused;
  logic        overprog_evt;
  logic [31:0] nxt_rdata;

  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge at which the master samples the acknowledge.
  assign bus_wr    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign wr_ctrl   = bus_wr && wb_adr_i == ufm_serial_pkg::OFS_CTRL;
  assign wr_status = bus_wr && wb_adr_i == ufm_serial_pkg::OFS_STATUS;
  assign refused   = req_seen && !start_prog && !start_erase;
  assign overprog_evt = op_done && state_ff == ufm_serial_pkg::ST_PROG
                        && wcnt_ff[op_addr_ff] >= 2'(ufm_serial_pkg::MAX_PROGRAMS);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_ff <= ufm_serial_pkg::CTRL_LOCK_RESET;
    end else if (wr_ctrl) begin
      lock_ff <= wb_dat_i[ufm_serial_pkg::CTRL_LOCK_BIT];
    end
  end

  // Sticky flags clear on a one written; a new event in that cycle wins.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ignored_ff  <= 1'b0;
      overprog_ff <= 1'b0;
    end else begin
      ignored_ff  <= refused | (ignored_ff &
                     !(wr_status && wb_dat_i[ufm_serial_pkg::STAT_IGNORED_BIT]));
      overprog_ff <= overprog_evt | (overprog_ff &
                     !(wr_status && wb_dat_i[ufm_serial_pkg::STAT_OVERPROG_BIT]));
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      ufm_serial_pkg::OFS_CTRL: begin
        nxt_rdata[ufm_serial_pkg::CTRL_LOCK_BIT] = lock_ff;
      end
      ufm_serial_pkg::OFS_STATUS: begin
        nxt_rdata[ufm_serial_pkg::STAT_BUSY_BIT]     = busy;
        nxt_rdata[ufm_serial_pkg::STAT_LIVE_BIT]     = live;
        nxt_rdata[ufm_serial_pkg::STAT_IGNORED_BIT]  = ignored_ff;
        nxt_rdata[ufm_serial_pkg::STAT_OVERPROG_BIT] = overprog_ff;
      end
      ufm_serial_pkg::OFS_ADDR: begin
        nxt_rdata[AW-1:0] = areg_ff;
      end
      ufm_serial_pkg::OFS_DATA: begin
        nxt_rdata[DW-1:0] = dreg_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  logic [DW-1:0] sector_first_word;
  assign sector_first_word = mem_ff[{op_addr_ff[AW-1], 8'h00}];

  sequence s_prog_start;
    rise.program_req && !lvl.erase_req && !busy && !lock_ff && !live;
  endsequence

  sequence s_busy_run;
    busy [*2];
  endsequence

  property p_prog_busy;
    @(posedge mclk) disable iff (rst)
      s_prog_start |=> s_busy_run;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("program start did not raise busy");

  property p_prog_ignored;
    @(posedge mclk) disable iff (rst)
      busy && rise.program_req |=> $stable(op_addr_ff) && $stable(op_data_ff);
  endproperty
  a_prog_ignored: assert property (p_prog_ignored) else $error("program taken while busy");

  property p_erase_ignored;
    @(posedge mclk) disable iff (rst)
      busy && rise.erase_req |=> $stable(op_addr_ff);
  endproperty
  a_erase_ignored: assert property (p_erase_ignored) else $error("erase taken while busy");

  property p_data_shift;
    @(posedge mclk) disable iff (rst)
      rise.dclk && lvl.dshift && !live |=> dreg_ff == {$past(dreg_ff[DW-2:0]), $past(lvl.din)};
  endproperty
  a_data_shift: assert property (p_data_shift) else $error("data register shift wrong");

  property p_capture;
    @(posedge mclk) disable iff (rst)
      rise.dclk && !lvl.dshift && !live |=> dreg_ff == $past(rd_word);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed addressed word");

  property p_addr_incr;
    @(posedge mclk) disable iff (rst)
      rise.aclk && !lvl.ashift && !live |=> areg_ff == $past(areg_ff) + AW'(1);
  endproperty
  a_addr_incr: assert property (p_addr_incr) else $error("address did not increment");

  property p_addr_hold;
    @(posedge mclk) disable iff (rst)
      !rise.aclk |=> $stable(areg_ff);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without clock");

  property p_data_hold;
    @(posedge mclk) disable iff (rst)
      !rise.dclk |=> $stable(dreg_ff);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved without clock");

  property p_busy_falls;
    @(posedge mclk) disable iff (rst)
      op_done |=> !busy;
  endproperty
  a_busy_falls: assert property (p_busy_falls) else $error("busy held after count");

  property p_erase_ones;
    @(posedge mclk) disable iff (rst)
      op_done && state_ff == ufm_serial_pkg::ST_ERASE |=>
        sector_first_word == ufm_serial_pkg::ERASED_WORD;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erased word not all ones");

endmodule : user_flash_serial_access

// >>> core/ufm_serial_pkg.sv
// Package of constants and carrier types for the user flash serial access block.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package ufm_serial_pkg;

  localparam int ADDR_W       = 9;
  localparam int DATA_W       = 16;
  localparam int WORDS        = 512;
  localparam int SECTOR_WORDS = 256;
  localparam int PROG_CYCLES  = 40;
  localparam int ERASE_CYCLES = 200;
  localparam int CNT_W        = 16;
  localparam int MAX_PROGRAMS = 2;

  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0c;

  // Field positions.
  localparam int CTRL_LOCK_BIT      = 0;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_LIVE_BIT      = 1;
  localparam int STAT_IGNORED_BIT   = 2;
  localparam int STAT_OVERPROG_BIT  = 3;

  localparam logic CTRL_LOCK_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b100
  } op_state_e;

  // Pin inputs that come from outside the clock domain.
  typedef struct packed {
    logic live_req;
    logic osc_en;
    logic erase_req;
    logic program_req;
    logic dshift;
    logic din;
    logic dclk;
    logic ashift;
    logic ain;
    logic aclk;
  } link_in_s;

  localparam int LINK_W = $bits(link_in_s);

endpackage : ufm_serial_pkg

// >>> core/input_filter.sv
// Three-stage input synchroniser with agreement filter and rising edge pulse.
`timescale 1ns/10ps
module input_filter #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] rise_ff;
  logic [W-1:0] nxt_level;

  // A new level is taken only when the second and third stages agree.
  always_comb begin
    nxt_level = (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      level_ff <= '0;
      rise_ff  <= '0;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
    end
  end

  assign level = level_ff;
  assign rise  = rise_ff;

endmodule : input_filter

// >>> tb/flash_user_model.sv
// Behavioural model of the fabric logic that drives the flash serial pins.
`timescale 1ns/10ps
module flash_user_model (
  input  wire logic        data_serial_out,
  input  wire logic        busy,
  input  wire logic        live_reprogram_active,
  output logic             addr_shift_clk,
  output logic             addr_serial_in,
  output logic             addr_shift_not_incr,
  output logic             data_shift_clk,
  output logic             data_shift_not_capture,
  output logic             data_serial_in,
  output logic             program_req,
  output logic             erase_req,
  output logic             internal_osc_enable,
  output logic      [15:0] rd_word,
  output logic             rd_strobe
);
  initial begin
    {addr_shift_clk, addr_serial_in, addr_shift_not_incr, data_shift_clk} = 4'h0;
    {data_shift_not_capture, data_serial_in, program_req, erase_req} = 4'h0;
    {internal_osc_enable, rd_strobe} = 2'b00;
    rd_word = 16'h0000;
  end
  // One 800 ns link period; controls only change while both clocks are low.
  task automatic edge_pair(input logic a_en, input logic d_en);
    #400;
    addr_shift_clk <= a_en & ~live_reprogram_active;
    data_shift_clk <= d_en & ~live_reprogram_active;
    #400;
    addr_shift_clk <= 1'b0;
    data_shift_clk <= 1'b0;
  endtask : edge_pair
  task automatic load(input logic a_en, input logic [8:0] a, input logic d_en,
                      input logic [15:0] d);
    addr_shift_not_incr <= 1'b1;
    data_shift_not_capture <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (i >= 7) addr_serial_in <= a[i-7];
      data_serial_in <= d[i];
      edge_pair(a_en && i >= 7, d_en);
    end
  endtask : load
  task automatic incr();
    addr_shift_not_incr <= 1'b0;
    edge_pair(1'b1, 1'b0);
    addr_shift_not_incr <= 1'b1;
  endtask : incr
  // Reads touch neither request line; the bit is sampled 390 ns into each 790 ns low phase, near its middle.
  task automatic read_word();
    logic [15:0] w;
    data_shift_not_capture <= 1'b0;
    edge_pair(1'b0, 1'b1);
    data_shift_not_capture <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      #390;
      w[i] = data_serial_out;
      if (i > 0) edge_pair(1'b0, 1'b1);
    end
    rd_word = w;
    rd_strobe = 1'b1;
    #100;
    rd_strobe = 1'b0;
  endtask : read_word
  // Registers are left alone until busy falls; a second edge is optional.
  task automatic run_op(input logic erase, input logic extra);
    int n;
    internal_osc_enable <= 1'b1;
    #1000;
    if (erase) erase_req <= 1'b1; else program_req <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      #100;
      n++;
    end
    #200;
    {program_req, erase_req} <= 2'b00;
    if (extra) begin
      #600;
      if (erase) erase_req <= 1'b1; else program_req <= 1'b1;
      #600;
      {program_req, erase_req} <= 2'b00;
    end
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      #100;
      n++;
    end
    internal_osc_enable <= 1'b0;
    #1000;
  endtask : run_op
endmodule : flash_user_model

// >>> tb/testbench.sv
// Self-checking bench for the user flash serial access block.
`timescale 1ns/10ps
module testbench;
  localparam int PROG  = 40;
  localparam int ERASE = 200;
  logic        mclk, rst, cyc, stb, we, live_req, ack, dout, busy, live, strobe;
  logic        aclk, ain, ashift, dclk, dshift, din, preq, ereq, osc;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [15:0] word, d1, d2, db;
  logic [8:0]  a, b;
  logic [15:0] exp_word[$];
  logic [31:0] exp_bus[$];
  int          failures, n_checks, busy_len, last_len;

  user_flash_serial_access #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) user_flash_serial_access_i (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .addr_shift_clk(aclk), .addr_serial_in(ain), .addr_shift_not_incr(ashift),
    .data_shift_clk(dclk), .data_shift_not_capture(dshift), .data_serial_in(din),
    .data_serial_out(dout), .program_req(preq), .erase_req(ereq), .internal_osc_enable(osc),
    .live_reprogram_req(live_req), .live_reprogram_active(live), .busy(busy));
  flash_user_model flash_user_model_i (
    .data_serial_out(dout), .busy(busy), .live_reprogram_active(live),
    .addr_shift_clk(aclk), .addr_serial_in(ain), .addr_shift_not_incr(ashift),
    .data_shift_clk(dclk), .data_shift_not_capture(dshift), .data_serial_in(din),
    .program_req(preq), .erase_req(ereq), .internal_osc_enable(osc),
    .rd_word(word), .rd_strobe(strobe));

  always #50 mclk = ~mclk;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  task automatic bad(input string msg);
    failures++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad
  task automatic cmp_word(input logic [15:0] got);
    logic [15:0] e;
    e = exp_word.pop_front();
    n_checks++;
    if (got !== e) bad($sformatf("word %h expected %h", got, e));
  endtask : cmp_word
  task automatic cmp_bus(input logic [31:0] got);
    logic [31:0] e;
    e = exp_bus.pop_front();
    n_checks++;
    if (got !== e) bad($sformatf("bus read %h expected %h", got, e));
  endtask : cmp_bus
  task automatic check_len(input int lo, input int hi);
    n_checks++;
    if (last_len < lo || last_len > hi) bad($sformatf("busy lasted %0d cycles", last_len));
  endtask : check_len
  task automatic check_bit(input logic got, input logic e);
    n_checks++;
    if (got !== e) bad("status pin level wrong");
  endtask : check_bit

  always @(posedge strobe) cmp_word(word);
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) cmp_bus(rdat);
  end
  always @(posedge mclk) begin
    if (busy === 1'b1) busy_len <= busy_len + 1;
    else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
  end

  // ---------------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------------
  task automatic wb_xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb} <= 2'b11;
    we <= w;
    adr <= ad;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    {cyc, stb} <= 2'b00;
  endtask : wb_xfer
  task automatic wb_rd(input logic [7:0] ad, input logic [31:0] e);
    exp_bus.push_back(e);
    wb_xfer(1'b0, ad, 32'h0);
  endtask : wb_rd
  task automatic rd_at(input logic [8:0] ad, input logic [15:0] e);
    flash_user_model_i.load(1'b1, ad, 1'b0, 16'h0);
    exp_word.push_back(e);
    flash_user_model_i.read_word();
  endtask : rd_at
  task automatic prog(input logic [8:0] ad, input logic [15:0] d, input logic extra);
    flash_user_model_i.load(1'b1, ad, 1'b1, d);
    flash_user_model_i.run_op(1'b0, extra);
  endtask : prog

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    #2ms;
    bad("watchdog expired");
    summarize();
  end

  initial begin
    {mclk, rst, cyc, stb, we, live_req, adr, wdat} = {6'b010000, 8'h00, 32'h0};
    {failures, n_checks, busy_len, last_len} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    void'($urandom(57));
    a = {1'b0, 8'($urandom % 255)};
    b = {1'b1, 8'($urandom)};
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    db = 16'($urandom);
    wb_rd(ufm_serial_pkg::OFS_CTRL, 32'h0);
    wb_rd(ufm_serial_pkg::OFS_STATUS, 32'h0);
    wb_rd(8'h10, 32'h0);
    wb_xfer(1'b1, 8'h10, 32'hffffffff);
    wb_rd(8'h10, 32'h0);
    prog(a, d1, 1'b1);
    check_len(PROG, PROG + 1);
    wb_rd(ufm_serial_pkg::OFS_ADDR, {23'h0, a});
    wb_rd(ufm_serial_pkg::OFS_DATA, {16'h0, d1});
    rd_at(a, d1);
    prog(a, d2, 1'b0);
    rd_at(a, d1 & d2);
    prog(a, 16'h0000, 1'b0);
    rd_at(a, d1 & d2);
    wb_rd(ufm_serial_pkg::OFS_STATUS, 32'hc);
    wb_xfer(1'b1, ufm_serial_pkg::OFS_STATUS, 32'hc);
    wb_rd(ufm_serial_pkg::OFS_STATUS, 32'h0);
    exp_word.push_back(d1 & d2);
    flash_user_model_i.read_word();
    flash_user_model_i.incr();
    wb_rd(ufm_serial_pkg::OFS_ADDR, {23'h0, a + 9'h1});
    exp_word.push_back(16'hffff);
    flash_user_model_i.read_word();
    prog(b, db, 1'b0);
    wb_xfer(1'b1, ufm_serial_pkg::OFS_CTRL, 32'h1);
    wb_rd(ufm_serial_pkg::OFS_CTRL, 32'h1);
    prog(b, 16'h0000, 1'b0);
    wb_rd(ufm_serial_pkg::OFS_STATUS, 32'h4);
    wb_xfer(1'b1, ufm_serial_pkg::OFS_CTRL, 32'h0);
    wb_xfer(1'b1, ufm_serial_pkg::OFS_STATUS, 32'h4);
    rd_at(b, db);
    flash_user_model_i.load(1'b1, a, 1'b0, 16'h0);
    flash_user_model_i.run_op(1'b1, 1'b1);
    check_len(ERASE, ERASE + 1);
    rd_at(a, 16'hffff);
    rd_at(b, db);
    live_req <= 1'b1;
    repeat (10) @(posedge mclk);
    check_bit(live, 1'b1);
    wb_rd(ufm_serial_pkg::OFS_STATUS, 32'h6);
    flash_user_model_i.load(1'b1, a, 1'b0, 16'h0);
    wb_rd(ufm_serial_pkg::OFS_ADDR, {23'h0, b});
    repeat (5) @(posedge mclk);
    summarize();
  end
endmodule : testbench
